// [vsio_cfg.svh]
`ifndef VSIO_CFG_SVH
`define VSIO_CFG_SVH
// Register offsets (byte addresses)
`define VSIO_OFF_CTRL    12'h000
`define VSIO_OFF_BORDER  12'h004
`define VSIO_OFF_DOTDIV  12'h008
`define VSIO_OFF_STATUS  12'h00C
`define VSIO_OFF_VIDIN   12'h010
// Control register field positions
`define VSIO_CTRL_OUTSEL 0
`define VSIO_CTRL_ATSRC  1
`define VSIO_CTRL_ATFIX  2
`define VSIO_CTRL_BSW    3
`define VSIO_CTRL_FSC_LO 4
`define VSIO_CTRL_FSC_HI 5
`define VSIO_CTRL_PLLEN  6
// Reset values
`define VSIO_CTRL_RST    7'h00
`define VSIO_BORDER_RST  24'h000000
`define VSIO_DOTDIV_RST  8'h02
// Display timing counts in dot clocks and lines
`define VSIO_H_TOTAL     12'h320
`define VSIO_H_SYNC      12'h060
`define VSIO_H_ACT_BEG   12'h090
`define VSIO_H_ACT_END   12'h310
`define VSIO_V_TOTAL     12'h20D
`define VSIO_V_SYNC      12'h002
`define VSIO_V_ACT_BEG   12'h023
`define VSIO_V_ACT_END   12'h203
`define VSIO_VR_LOWS     2'h3
`endif

// [vsio_pkg.sv]
package vsio_pkg;
   typedef enum logic [1:0] {VR_WATCH = 2'b01, VR_ARMED = 2'b10} vsio_vr_state_t;
   typedef enum logic [1:0] {
      FSC_DIV1 = 2'h0, FSC_DIV2 = 2'h1, FSC_DIV4 = 2'h2, FSC_DIV8 = 2'h3
   } vsio_fsc_div_t;
   typedef logic [7:0] vsio_pix_t;
endpackage

// [vsio_if.sv]
`timescale 1ns/1ps
interface vsio_if;
   logic dot_tick;
   logic hreset_fall;
   logic vreset_in;
   logic hsync;
   logic vsync;
   logic active;
   logic field;
   logic vr_armed;
   modport timing (input dot_tick, hreset_fall, vreset_in,
                   output hsync, vsync, active, field, vr_armed);
   modport ctrl (output dot_tick, hreset_fall, vreset_in,
                 input hsync, vsync, active, field, vr_armed);
endinterface

// [vsio_timing.sv]
`timescale 1ns/1ps
`include "vsio_cfg.svh"
module vsio_timing #(
   parameter logic [11:0] H_TOTAL = `VSIO_H_TOTAL,
   parameter logic [11:0] H_SYNC  = `VSIO_H_SYNC,
   parameter logic [11:0] H_BEG   = `VSIO_H_ACT_BEG,
   parameter logic [11:0] H_END   = `VSIO_H_ACT_END,
   parameter logic [11:0] V_TOTAL = `VSIO_V_TOTAL,
   parameter logic [11:0] V_SYNC  = `VSIO_V_SYNC,
   parameter logic [11:0] V_BEG   = `VSIO_V_ACT_BEG,
   parameter logic [11:0] V_END   = `VSIO_V_ACT_END
) (
   // Clock and reset
   input wire logic   pclk,
   input wire logic   presetn,
   // Timing link to the pin logic
   vsio_if.timing     tif
);
   import vsio_pkg::*;

   generate
      if (H_SYNC == 12'h000 || H_SYNC >= H_BEG || H_END > H_TOTAL || V_END > V_TOTAL) begin : g_bad
         $error("vsio_timing: inconsistent timing parameters");
      end
   endgenerate

   logic [11:0]    hcnt, next_hcnt, vcnt, next_vcnt, smp, next_smp;
   logic [1:0]     lows, next_lows;
   logic           field, next_field, wrap, sample;
   vsio_vr_state_t st, next_st;

   ////////////////////////////////////////////////////////////////////////
   // Counters, vertical reset watcher and field identification
   always_comb begin
      next_hcnt  = hcnt;
      next_vcnt  = vcnt;
      next_smp   = smp;
      next_lows  = lows;
      next_st    = st;
      next_field = field;
      wrap       = tif.dot_tick && (hcnt == H_TOTAL - 12'h001);
      sample     = tif.dot_tick && (smp == H_SYNC - 12'h001);
      if (tif.hreset_fall) begin
         next_hcnt = 12'h000; // RULE13
         next_smp  = 12'h000;
      end else if (tif.dot_tick) begin
         next_hcnt = wrap ? 12'h000 : hcnt + 12'h001;
         next_smp  = sample ? 12'h000 : smp + 12'h001;
      end
      if (wrap && !tif.hreset_fall) begin
         next_vcnt = (vcnt == V_TOTAL - 12'h001) ? 12'h000 : vcnt + 12'h001;
      end
      case (st)
         VR_WATCH: begin
            if (sample && tif.vreset_in) begin
               next_lows = 2'h0; // RULE22
            end else if (sample && lows == `VSIO_VR_LOWS - 2'h1) begin
               next_lows  = 2'h0;
               next_st    = VR_ARMED; // RULE10
               next_field = (hcnt >= {1'b0, H_TOTAL[11:1]}); // RULE11
            end else if (sample) begin
               next_lows = lows + 2'h1;
            end
         end
         VR_ARMED: begin
            if (wrap || tif.hreset_fall) begin
               next_vcnt = 12'h000; // RULE10
               next_st   = VR_WATCH;
            end
         end
         default: next_st = VR_WATCH;
      endcase
   end

   // Counter registers and registered sync and display flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt         <= 12'h000;
         vcnt         <= 12'h000;
         smp          <= 12'h000;
         lows         <= 2'h0;
         st           <= VR_WATCH;
         field        <= 1'b0;
         tif.hsync    <= 1'b0;
         tif.vsync    <= 1'b0;
         tif.active   <= 1'b0;
         tif.field    <= 1'b0;
         tif.vr_armed <= 1'b0;
      end else begin
         hcnt         <= next_hcnt;
         vcnt         <= next_vcnt;
         smp          <= next_smp;
         lows         <= next_lows;
         st           <= next_st;
         field        <= next_field;
         tif.hsync    <= next_hcnt < H_SYNC;
         tif.vsync    <= next_vcnt < V_SYNC;
         tif.active   <= next_hcnt >= H_BEG && next_hcnt < H_END
                         && next_vcnt >= V_BEG && next_vcnt < V_END;
         tif.field    <= next_field;
         tif.vr_armed <= next_st == VR_ARMED;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_VR_LINE: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      st == VR_ARMED && tif.dot_tick && hcnt == H_TOTAL - 12'h001 |=> vcnt == 12'h000 && hcnt == 12'h000)
      else $error("vertical counter not reset at line sync start");
   AST_VR_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
      st == VR_WATCH && sample && tif.vreset_in |=> lows == 2'h0 && st == VR_WATCH)
      else $error("low sample run not cleared by high sample");
   AST_H_RESET: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      tif.hreset_fall |=> hcnt == 12'h000 ##1 tif.hsync)
      else $error("horizontal reset did not reach sync start");
endmodule

// [vsio_top.sv]
// Overview of operation
// [RULE1] Subcarrier clock is the dot clock divided by one, two, four or eight.
// [RULE2] Colour, video bus, switch and attribute outputs change with pixel clock.
// [RULE3] Video bus is input only when direction pin high and out select 0.
// [RULE4] With register direction control the pin is held high or left open.
// [RULE5] Video bus packs three six-bit components, red top, blue bottom.
// [RULE6] Switch output is inverted dot switch bit, inverted border switch otherwise.
// [RULE7] Attribute source 0 presents the fixed attribute bit.
// [RULE8] Attribute source 1 presents blue lsb; blue converter lsb copies msb.
// [RULE9] Blanking with attribute source 1 presents border blue lsb.
// [RULE10] Three low vertical reset samples reset vertical count at next line sync.
// [RULE11] Field is identified at vertical reset from composite sync.
// [RULE12] Source avoids vertical reset during active display.
// [RULE13] Horizontal reset fall sets sync start and resets dot phase.
// [RULE14] External sync locks horizontal sync to the horizontal reset input.
// [RULE15] Source avoids horizontal reset during active display.
// [RULE16] Source select low: all from dot clock; high: system reference separate.
// [RULE17] Stable dot clock input and fixed source select level are supplied.
// [RULE18] Without PLL the dot clock input directly drives timing and data.
// [RULE19] Subcarrier PLL mode needs a reference of a subcarrier multiple.
// [RULE20] Memory clock is made from the system reference clock; here only with source select high, else from half_tick.
// [RULE21] Blanking output is asserted throughout the non-display period.
// [RULE22] A high vertical reset sample clears the low sample run.
`timescale 1ns/1ps
`include "vsio_cfg.svh"
module vsio_top (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Clock pins
   input  wire logic               dot_ref_clock_in,
   input  wire logic               system_ref_clock_in,
   input  wire logic               clock_source_select,
   output logic                    pixel_clock_out,
   output logic                    subcarrier_clock_out,
   output logic                    mem_clock_out,
   // Sync pins
   input  wire logic               vertical_reset_in,
   input  wire logic               horizontal_reset_in,
   output logic                    hsync_out,
   output logic                    vsync_out,
   output logic                    blank_out,
   // Pixel stream from the display pipeline
   input  wire vsio_pkg::vsio_pix_t pix_r,
   input  wire vsio_pkg::vsio_pix_t pix_g,
   input  wire vsio_pkg::vsio_pix_t pix_b,
   input  wire logic               per_dot_switch_bit,
   output vsio_pkg::vsio_pix_t     dac_r,
   output vsio_pkg::vsio_pix_t     dac_g,
   output vsio_pkg::vsio_pix_t     dac_b,
   output logic                    superimpose_switch_out,
   output logic                    attribute_out,
   // External video port
   input  wire logic               video_port_direction_pin,
   input  wire logic [17:0]        ext_video_bus_in,
   output logic      [17:0]        ext_video_bus_out,
   output logic                    ext_video_bus_oe
);
   import vsio_pkg::*;

   vsio_if tif ();

   logic [6:0]    ctrl, next_ctrl;
   logic [23:0]   border, next_border;
   logic [7:0]    dotdiv, next_dotdiv, pll_cnt, next_pll_cnt;
   logic [17:0]   vidin, next_vidin;
   logic [31:0]   next_prdata, rd_val;
   logic          next_pslverr, mapped, wr_en;
   logic          dot_prev, sys_prev, hr_prev;
   logic [3:0]    phase, next_phase;
   logic          half_tick, sys_half, pll_tick, dot_tick, hreset_fall;
   vsio_fsc_div_t ratio;
   vsio_pix_t     c_r, c_g, c_b;

   ////////////////////////////////////////////////////////////////////////
   // APB register decode; zero wait states, error on unmapped address
   always_comb begin
      wr_en  = psel && penable && pwrite;
      mapped = 1'b1;
      rd_val = 32'h00000000;
      case (paddr)
         `VSIO_OFF_CTRL:   rd_val = {25'h0000000, ctrl};
         `VSIO_OFF_BORDER: rd_val = {8'h00, border};
         `VSIO_OFF_DOTDIV: rd_val = {24'h000000, dotdiv};
         `VSIO_OFF_STATUS: rd_val = {27'h0000000, tif.vr_armed, ext_video_bus_oe,
                                     blank_out, tif.field, clock_source_select};
         `VSIO_OFF_VIDIN:  rd_val = {14'h0000, vidin};
         default:          mapped = 1'b0;
      endcase
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (psel && !penable) begin
         next_prdata  = pwrite ? 32'h00000000 : rd_val;
         next_pslverr = !mapped;
      end
      next_ctrl   = ctrl;
      next_border = border;
      next_dotdiv = dotdiv;
      if (wr_en && paddr == `VSIO_OFF_CTRL) begin
         next_ctrl = pwdata[6:0];
      end
      if (wr_en && paddr == `VSIO_OFF_BORDER) begin
         next_border = pwdata[23:0];
      end
      if (wr_en && paddr == `VSIO_OFF_DOTDIV) begin
         next_dotdiv = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
      end
   end

   // Register file and bus answer flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl    <= `VSIO_CTRL_RST;
         border  <= `VSIO_BORDER_RST;
         dotdiv  <= `VSIO_DOTDIV_RST;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         ctrl    <= next_ctrl;
         border  <= next_border;
         dotdiv  <= next_dotdiv;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock selection, dot phase and divided clocks
   always_comb begin
      ratio        = vsio_fsc_div_t'(ctrl[`VSIO_CTRL_FSC_HI:`VSIO_CTRL_FSC_LO]);
      pll_tick     = pll_cnt >= dotdiv - 8'h01;
      next_pll_cnt = pll_tick ? 8'h00 : pll_cnt + 8'h01;
      hreset_fall  = hr_prev && !horizontal_reset_in;
      // Without the PLL every input edge is a pixel half period
      half_tick    = ctrl[`VSIO_CTRL_PLLEN] ? pll_tick
                                           : (dot_ref_clock_in ^ dot_prev); // RULE18
      // Source select picks the reference for the memory clock
      sys_half     = clock_source_select ? (system_ref_clock_in ^ sys_prev)
                                         : half_tick; // RULE16
      dot_tick     = half_tick && !phase[0] && !hreset_fall;
      next_phase   = phase;
      if (ctrl[`VSIO_CTRL_PLLEN] && hreset_fall) begin
         next_pll_cnt = 8'h00; // RULE14
      end
      if (hreset_fall) begin
         next_phase = 4'h0; // RULE13
      end else if (half_tick) begin
         next_phase = phase + 4'h1;
      end
   end

   // Pixel and subcarrier clock pins come from the phase counter, memory clock from sys_half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_cnt              <= 8'h00;
         phase                <= 4'h0;
         dot_prev             <= 1'b0;
         sys_prev             <= 1'b0;
         hr_prev              <= 1'b1;
         pixel_clock_out      <= 1'b0;
         subcarrier_clock_out <= 1'b0;
         mem_clock_out        <= 1'b0;
      end else begin
         pll_cnt              <= next_pll_cnt;
         phase                <= next_phase;
         dot_prev             <= dot_ref_clock_in;
         sys_prev             <= system_ref_clock_in;
         hr_prev              <= horizontal_reset_in;
         pixel_clock_out      <= next_phase[0];
         subcarrier_clock_out <= next_phase[ratio]; // RULE1
         mem_clock_out        <= mem_clock_out ^ sys_half; // RULE20
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Display timing
   assign tif.dot_tick    = dot_tick;
   assign tif.hreset_fall = hreset_fall;
   assign tif.vreset_in   = vertical_reset_in;

   vsio_timing u_timing (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif)
   );

   ////////////////////////////////////////////////////////////////////////
   // Pixel output stage
   always_comb begin
      c_r        = tif.active ? pix_r : border[23:16];
      c_g        = tif.active ? pix_g : border[15:8];
      c_b        = tif.active ? pix_b : border[7:0];
      next_vidin = vidin;
      if (dot_tick && !ext_video_bus_oe) begin
         next_vidin = ext_video_bus_in;
      end
   end

   // Everything below except ext_video_bus_oe moves on the rising pixel clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_r                  <= 8'h00;
         dac_g                  <= 8'h00;
         dac_b                  <= 8'h00;
         ext_video_bus_out      <= 18'h00000;
         ext_video_bus_oe       <= 1'b0;
         superimpose_switch_out <= 1'b1;
         attribute_out          <= 1'b0;
         blank_out              <= 1'b1;
         hsync_out              <= 1'b0;
         vsync_out              <= 1'b0;
         vidin                  <= 18'h00000;
      end else begin
         vidin            <= next_vidin;
         // Direction follows the pin and the select bit on the next pclk
         ext_video_bus_oe <= !video_port_direction_pin || ctrl[`VSIO_CTRL_OUTSEL]; // RULE3
         if (dot_tick) begin // RULE2
            dac_r             <= c_r;
            dac_g             <= c_g;
            dac_b             <= ctrl[`VSIO_CTRL_ATSRC] ? {c_b[7:1], c_b[7]} : c_b; // RULE8
            ext_video_bus_out <= {c_r[7:2], c_g[7:2], c_b[7:2]}; // RULE5
            superimpose_switch_out <= tif.active ? !per_dot_switch_bit
                                                 : !ctrl[`VSIO_CTRL_BSW]; // RULE6
            attribute_out     <= ctrl[`VSIO_CTRL_ATSRC] ? c_b[0] // RULE9
                                                        : ctrl[`VSIO_CTRL_ATFIX]; // RULE7
            blank_out         <= !tif.active; // RULE21
            hsync_out         <= tif.hsync;
            vsync_out         <= tif.vsync;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_FSC_DIV1: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      $past(ratio) == FSC_DIV1 |-> subcarrier_clock_out == pixel_clock_out)
      else $error("subcarrier not equal to pixel clock at ratio one");
   AST_FSC_DIV2: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      $past(ratio) == FSC_DIV2 && $past(ratio, 2) == FSC_DIV2 && $rose(subcarrier_clock_out)
      && !$past(hreset_fall) |-> !pixel_clock_out)
      else $error("divide by two subcarrier out of step");
   AST_PIX_STEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      $changed(dac_r) || $changed(ext_video_bus_out) |-> $rose(pixel_clock_out))
      else $error("display data changed off the pixel clock");
   AST_DIR: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      video_port_direction_pin && !ctrl[`VSIO_CTRL_OUTSEL] ##1
      video_port_direction_pin && !ctrl[`VSIO_CTRL_OUTSEL] |=> !ext_video_bus_oe)
      else $error("video bus driven while set to input");
   AST_BUS_FMT: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      $rose(pixel_clock_out) |-> ext_video_bus_out[17:12] == dac_r[7:2]
      && ext_video_bus_out[11:6] == dac_g[7:2])
      else $error("video bus component packing wrong");
   AST_YS: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      $rose(pixel_clock_out) && !blank_out |-> superimpose_switch_out == !$past(per_dot_switch_bit))
      else $error("switch output not inverted dot bit");
   AST_AT_FIX: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      $rose(pixel_clock_out) && !$past(ctrl[`VSIO_CTRL_ATSRC])
      |-> attribute_out == $past(ctrl[`VSIO_CTRL_ATFIX]))
      else $error("attribute not the fixed bit");
   AST_AT_BLSB: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      $rose(pixel_clock_out) && $past(ctrl[`VSIO_CTRL_ATSRC]) |-> dac_b[0] == dac_b[7])
      else $error("blue converter lsb not copy of msb");
   AST_AT_BLANK: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      $rose(pixel_clock_out) && $past(ctrl[`VSIO_CTRL_ATSRC]) && blank_out
      |-> attribute_out == $past(border[0]))
      else $error("attribute not border blue lsb in blanking");
   AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      hreset_fall |=> !pixel_clock_out && phase == 4'h0)
      else $error("dot phase not reset by horizontal reset");
endmodule

// [vsio_src_model.sv]
`timescale 1ns/1ps
module vsio_src_model (
   // Sync and direction levels requested by the bench
   input  wire logic        hres_n,
   input  wire logic        vres_n,
   input  wire logic        dir_n,
   // Block's side of the video port
   input  wire logic [17:0] ext_video_bus_out,
   input  wire logic        ext_video_bus_oe,
   // Pins toward the block
   output logic             dot_ref_clock_in,
   output logic             system_ref_clock_in,
   output logic             horizontal_reset_in,
   output logic             vertical_reset_in,
   output logic             video_port_direction_pin,
   output logic [17:0]      ext_video_bus_in
);
   // Free running dot reference, unrelated to pclk
   initial begin
      dot_ref_clock_in = 1'b0;
      forever #28.5 dot_ref_clock_in = ~dot_ref_clock_in;
   end
   // Free running system reference
   initial begin
      system_ref_clock_in = 1'b0;
      forever #23 system_ref_clock_in = ~system_ref_clock_in;
   end
   // Sync levels; bench only pulls them low outside active display
   assign horizontal_reset_in = hres_n;
   assign vertical_reset_in   = vres_n;
   assign video_port_direction_pin = dir_n;
   // Wire level: block's drive, else pull-ups
   assign ext_video_bus_in = ext_video_bus_oe ? ext_video_bus_out : 18'h3FFFF;
endmodule

// [video_sync_io_and_clock_select_bench.sv]
`timescale 1ns/1ps
`include "vsio_cfg.svh"
module video_sync_io_and_clock_select_bench;
   import vsio_pkg::*;
   typedef struct packed {
      logic [17:0] bus;
      vsio_pix_t   r, g, b;
      logic        at_a, ys_a, at_k, ys_k;
   } vsio_note_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rise;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   vsio_pix_t   pix_r, pix_g, pix_b, dac_r, dac_g, dac_b;
   logic        per_dot_switch_bit, pixel_clock_out, subcarrier_clock_out, mem_clock_out;
   logic        hsync_out, vsync_out, blank_out, superimpose_switch_out, attribute_out;
   logic        dot_ref_clock_in, system_ref_clock_in, clock_source_select;
   logic        horizontal_reset_in, vertical_reset_in, video_port_direction_pin;
   logic        hres_n, vres_n, dir_n, ext_video_bus_oe, bk_q, bk_qq, px_q = 1'b0;
   logic [17:0] ext_video_bus_in, ext_video_bus_out;
   logic [43:0] sn;
   logic [43:0] o_q;
   wire  [43:0] o_now = {dac_r, dac_g, dac_b, ext_video_bus_out,
                         superimpose_switch_out, attribute_out};
   int          fails, total_checks, seed, i, m, c_px, c_sc, c_mc, c_dr, c_sr;
   vsio_note_t  notes[$];
   vsio_note_t  t;
   ////////////////////////////////////////////////////////////////////////////
   vsio_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .dot_ref_clock_in, .system_ref_clock_in, .clock_source_select,
      .pixel_clock_out, .subcarrier_clock_out, .mem_clock_out, .vertical_reset_in,
      .horizontal_reset_in, .hsync_out, .vsync_out, .blank_out, .pix_r, .pix_g, .pix_b,
      .per_dot_switch_bit, .dac_r, .dac_g, .dac_b, .superimpose_switch_out,
      .attribute_out, .video_port_direction_pin, .ext_video_bus_in,
      .ext_video_bus_out, .ext_video_bus_oe);
   vsio_src_model PARTNER (.hres_n, .vres_n, .dir_n, .ext_video_bus_out,
      .ext_video_bus_oe, .dot_ref_clock_in, .system_ref_clock_in,
      .horizontal_reset_in, .vertical_reset_in, .video_port_direction_pin,
      .ext_video_bus_in);
   ////////////////////////////////////////////////////////////////////////////
   // Clock and edge counters
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pixel_clock_out) c_px++;
   always @(posedge subcarrier_clock_out) c_sc++;
   always @(posedge mem_clock_out) c_mc++;
   always @(posedge dot_ref_clock_in) c_dr++;
   always @(posedge system_ref_clock_in) c_sr++;
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic near(input int a, input int e);
      chk({31'h0, a >= e - 1 && a <= e + 1}, 32'h1);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One APB transfer, result left in rd and err
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counting window of 1024 cycles
   task automatic win;
      {c_px, c_sc, c_mc, c_dr, c_sr} = '0;
      repeat (1024) @(posedge pclk);
   endtask
   // Random pixel and border, attribute modes from i
   task automatic pix_case(input int i);
      logic [24:0] v;
      logic [23:0] bd;
      v = 25'($random(seed));
      bd = 24'($random(seed));
      apb(1'b1, 12'h004, {8'h00, bd});
      apb(1'b1, 12'h000, 32'h41 | 32'((i % 8) << 1));
      {per_dot_switch_bit, pix_r, pix_g, pix_b} <= v;
      if (i > 3) while (blank_out) @(posedge pclk);
      repeat (20) @(posedge pclk);
      notes.push_back('{{v[23:18], v[15:10], v[7:2]}, v[23:16], v[15:8],
                        i[0] ? {v[7:1], v[7]} : v[7:0],
                        i[0] ? v[0] : i[1], ~v[24], i[0] ? bd[0] : i[1], ~i[2]});
      while (notes.size() > 0) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Output watcher: pixel outputs move only at pixel clock rise
   always @(negedge pclk) begin
      rise = pixel_clock_out && !px_q;
      if (presetn) chk({31'h0, rise || o_now === o_q}, 32'h1);
      if (rise) begin
         if (notes.size() > 0 && blank_out === bk_q && bk_q === bk_qq) begin
            t = notes.pop_front();
            if (!bk_q) begin
               chk(sn[19:2], t.bus);
               chk(sn[43:36], t.r);
               chk(sn[35:28], t.g);
               chk(sn[27:20], t.b);
               chk(sn[0], t.at_a);
               chk(sn[1], t.ys_a);
            end else begin
               chk(sn[0], t.at_k);
               chk(sn[1], t.ys_k);
            end
         end
         if (vsync_out) chk(blank_out, 1'b1);
         bk_qq = bk_q;
         bk_q = blank_out;
         sn = o_now;
      end
      px_q = pixel_clock_out;
      o_q = o_now;
   end
   // Watchdog
   initial begin
      #900000;
      fails++;
      $display("MISMATCH at %0t: run timed out", $time);
      tally_and_finish;
   end
   // Main sequence
   initial begin
      seed = 10743;
      {fails, total_checks} = '0;
      {presetn, psel, penable, pwrite, paddr, pwdata, pix_r, pix_g, pix_b} = '0;
      {per_dot_switch_bit, hres_n, vres_n, dir_n, clock_source_select} = 5'h0F;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h3FFFF);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 12'h008, 32'h1);
      for (i = 0; i < 4; i++) begin
         dir_n <= i[0];
         apb(1'b1, 12'h000, 32'h40 | 32'(i >> 1));
         repeat (4) @(posedge pclk);
         chk(ext_video_bus_oe, !(i[0] && !i[1]));
      end
      for (i = 0; i < 4; i++) begin
         apb(1'b1, 12'h000, 32'h41 | 32'(i << 4));
         win;
         near(c_px, 512);
         near(c_sc, c_px >> i);
      end
      near(c_mc, c_sr);
      apb(1'b1, 12'h000, 32'h01);
      win;
      near(c_px, c_dr);
      apb(1'b1, 12'h000, 32'h41);
      // Line restart from the horizontal reset, away from natural sync
      while (!hsync_out) @(posedge pclk);
      while (hsync_out) @(posedge pclk);
      repeat (40) @(posedge pclk);
      hres_n <= 1'b0;
      for (m = 0; m < 12 && !hsync_out; m++) @(posedge pclk);
      c_px = 0;
      chk(hsync_out, 1'b1);
      while (hsync_out) @(posedge pclk);
      near(c_px, `VSIO_H_SYNC);
      hres_n <= 1'b1;
      // Vertical reset samples every 192 cycles: broken runs, then a full run
      while (vsync_out) @(posedge pclk);
      vres_n <= 1'b0;
      repeat (300) @(posedge pclk);
      vres_n <= 1'b1;
      repeat (250) @(posedge pclk);
      vres_n <= 1'b0;
      repeat (300) @(posedge pclk);
      vres_n <= 1'b1;
      m = 0;
      repeat (1700) @(posedge pclk) m |= vsync_out;
      chk(m, 0);
      vres_n <= 1'b0;
      repeat (700) @(posedge pclk);
      vres_n <= 1'b1;
      repeat (2400) @(posedge pclk) m |= vsync_out;
      chk(m, 1);
      for (i = 0; i < 4; i++) pix_case(i);
      repeat (50000) @(posedge pclk);
      for (i = 4; i < 8; i++) pix_case(i);
      tally_and_finish;
   end
endmodule
